/* File: design/mac_address_filter_engine.sv */
// Notes on behaviour
// - Chain enable low through strobe when comparing.
// - Match input is last CAM's match flag.
// - Full input is last CAM's full flag.
// - CAM reset low in reset; software raises.
// - Register receive nibbles on receive clock.
// - Scan preamble and delimiter to find addresses.
// - Network work beats host CAM requests.
// - Classify; search unicast, groups when enabled.
// - Reject when destination port equals source.
// - Serial tag out on differing port match.
// - Unfound group takes configured default action.
// - Reject asserts reject and forwarded error.
// - Store result with type, port, outcome.
// - Host reads result from result register.
// - Result valid high while result waits.
// - Advance discards current, shows next result.
// - Hold source address, port and stamp.
// - Bad CRC or length abandons learning.
// - Good frames compare source address in CAM.
// - Refresh matched entry, else add new.
// - Type codes 00 broadcast, 01 multicast, 10 unicast.
// - Result word field layout is fixed.
// - Advance acts only while select high.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module mac_address_filter_engine import mac_filter_pkg::*; #(
  parameter int          RESULT_DEPTH = 4,
  parameter logic [15:0] LEARN_OPCODE = 16'h0000
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_CLK,
  input  wire logic        RX_DV,
  input  wire logic [3:0]  RXD,
  input  wire logic        RX_ER,
  output logic             FRAME_REJECT,
  output logic             FORWARDED_RX_ERROR,
  output logic             TAG_VALID,
  output logic             TAG_DATA,
  output logic      [15:0] RESULT_DATA,
  output logic             RESULT_OE_N,
  output logic             RESULT_VALID,
  input  wire logic        RESULT_SELECT,
  input  wire logic        RESULT_ADVANCE,
  input  wire logic [15:0] CAM_DQ_IN,
  output logic      [15:0] CAM_DQ_OUT,
  output logic             CAM_DQ_OE_N,
  output logic             CAM_ENABLE_N,
  output logic             CAM_WRITE_N,
  output logic             CAM_COMMAND_N,
  output logic             CHAIN_ENABLE_N,
  input  wire logic        MATCH_IN_N,
  input  wire logic        FULL_IN_N,
  output logic             CAM_RESET_N
);

  localparam int PW = (RESULT_DEPTH > 1) ? $clog2(RESULT_DEPTH) : 1;
  localparam int CW = $clog2(RESULT_DEPTH + 1);

  logic [26:0]  sync1;
  logic [26:0]  sync2;
  logic         rx_clk_s, rx_dv_s, rx_er_s, match_n_s, full_n_s, sel_s, adv_s;
  logic [3:0]   rxd_s;
  logic [15:0]  dq_s;
  logic         rx_clk_d, adv_d, rx_fall, rx_rise, adv_pulse;
  logic [3:0]   pcx;
  logic [5:0]   src_port;
  logic [7:0]   stamp;
  logic         host_pending;
  logic [18:0]  host_word;
  logic         apb_wr, apb_setup_rd, apb_pop, addr_hit;
  frame_state_t fstate;
  logic [11:0]  nibs;
  logic [47:0]  da, sa, sa_hold, next_da;
  logic [15:0]  sa_assoc;
  logic [31:0]  crc, next_crc;
  logic         err, da_req, sa_req, skip_done, frame_start, frame_end;
  logic [1:0]   ftype;
  logic         group;
  seq_state_t   qstate;
  job_t         job;
  logic [2:0]   step;
  logic [3:0]   cnt;
  logic         hit, da_take, sa_take, host_done, da_done;
  logic [15:0]  rd_word;
  logic         p_cm_n, p_w_n, p_ec_n, p_last;
  logic [15:0]  p_data;
  logic         res_trig, res_hit, same_port;
  logic [5:0]   res_port;
  logic [15:0]  res_word;
  logic [15:0]  res_mem [RESULT_DEPTH];
  logic [PW-1:0] wp, rp;
  logic [CW-1:0] count;
  logic         pop, push;
  logic [5:0]   tag_shift;
  logic [2:0]   tag_cnt;

  // One CAM data word of an address, first received byte high.
  function automatic logic [15:0] addr_word(input logic [47:0] a, input logic [2:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      3'd0:    w = {a[7:0], a[15:8]};
      3'd1:    w = {a[23:16], a[31:24]};
      default: w = {a[39:32], a[47:40]};
    endcase
    return w;
  endfunction : addr_word

  // Every pin from outside except the APB bus and reset passes two flip-flops; match and full come from the chain end.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1 <= 27'h0000000;
      sync2 <= 27'h0000000;
    end else begin
      sync1 <= {RX_CLK, RX_DV, RXD, RX_ER, MATCH_IN_N, FULL_IN_N, RESULT_SELECT,
                RESULT_ADVANCE, CAM_DQ_IN};
      sync2 <= sync1;
    end
  end

  assign {rx_clk_s, rx_dv_s, rxd_s, rx_er_s, match_n_s, full_n_s, sel_s, adv_s, dq_s} = sync2;

  // Edge finders on the synchronised receive clock and the advance strobe.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_clk_d <= 1'b0;
      adv_d    <= 1'b0;
    end else begin
      rx_clk_d <= rx_clk_s;
      adv_d    <= adv_s;
    end
  end

  // Nibbles are taken on the falling edge, mid-bit, where the data is settled.
  assign rx_fall   = rx_clk_d & ~rx_clk_s;
  assign rx_rise   = ~rx_clk_d & rx_clk_s;
  assign adv_pulse = adv_s & ~adv_d & sel_s;

  // APB decode; the slave never inserts wait states.
  assign apb_wr       = PSEL & PENABLE & PWRITE;
  assign apb_setup_rd = PSEL & ~PENABLE & ~PWRITE;
  assign PREADY       = 1'b1;
  always_comb begin
    case (PADDR)
      OFF_SYS_DYNAMIC_CONFIG, OFF_PORT_CONFIG_EXTENDED, OFF_SOURCE_PORT, OFF_TIME_STAMP,
      OFF_RESULT_DATA, OFF_STATUS, OFF_HOST_CAM: addr_hit = 1'b1;
      default:                                   addr_hit = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL & PENABLE & ~addr_hit;
  // Reading the result register drains the queue only when the result port is not in use.
  assign apb_pop = PSEL & PENABLE & ~PWRITE & (PADDR == OFF_RESULT_DATA) & ~sel_s;

  // Software-written configuration and the host CAM request.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CAM_RESET_N  <= 1'b0;
      pcx          <= PCX_RESET;
      src_port     <= PORT_RESET;
      stamp        <= STAMP_RESET;
      host_pending <= 1'b0;
      host_word    <= 19'h00000;
    end else begin
      if (host_done) begin
        host_pending <= 1'b0;
      end
      if (apb_wr) begin
        case (PADDR)
          OFF_SYS_DYNAMIC_CONFIG:   CAM_RESET_N <= PWDATA[CFG_CAM_RUN_BIT];
          OFF_PORT_CONFIG_EXTENDED: pcx         <= PWDATA[3:0];
          OFF_SOURCE_PORT:          src_port    <= PWDATA[5:0];
          OFF_TIME_STAMP:           stamp       <= PWDATA[7:0];
          OFF_HOST_CAM: begin
            if (!host_pending) begin
              host_word    <= PWDATA[18:0];
              host_pending <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Read data is captured in the setup phase so it stands through the access phase.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h00000000;
    end else if (apb_setup_rd) begin
      case (PADDR)
        OFF_SYS_DYNAMIC_CONFIG:   PRDATA <= {31'h0, CAM_RESET_N};
        OFF_PORT_CONFIG_EXTENDED: PRDATA <= {28'h0, pcx};
        OFF_SOURCE_PORT:          PRDATA <= {26'h0, src_port};
        OFF_TIME_STAMP:           PRDATA <= {24'h0, stamp};
        OFF_RESULT_DATA:          PRDATA <= {15'h0, RESULT_VALID, RESULT_DATA};
        OFF_STATUS:               PRDATA <= {29'h0, host_pending, ~full_n_s, RESULT_VALID};
        OFF_HOST_CAM:             PRDATA <= {host_pending, 15'h0, rd_word};
        default:                  PRDATA <= 32'h00000000;
      endcase
    end
  end

  // Next address shift value and frame check update for the current nibble.
  always_comb begin
    next_da  = {rxd_s, da[47:4]};
    next_crc = crc;
    for (int i = 0; i < 4; i++) begin
      next_crc = (next_crc[0] ^ rxd_s[i]) ? ((next_crc >> 1) ^ CRC_POLY) : (next_crc >> 1);
    end
  end

  // Receive parser: preamble, delimiter, addresses, body, and end-of-frame checks.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      fstate      <= F_IDLE;
      nibs        <= 12'h000;
      da          <= 48'h0;
      sa          <= 48'h0;
      sa_hold     <= 48'h0;
      sa_assoc    <= 16'h0000;
      crc         <= CRC_INIT;
      err         <= 1'b0;
      ftype       <= TYPE_UCAST;
      group       <= 1'b0;
      da_req      <= 1'b0;
      sa_req      <= 1'b0;
      skip_done   <= 1'b0;
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
    end else begin
      skip_done   <= 1'b0;
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
      if (da_take) begin
        da_req <= 1'b0;
      end
      if (sa_take) begin
        sa_req <= 1'b0;
      end
      if (rx_fall) begin
        case (fstate)
          F_IDLE: begin
            if (rx_dv_s && rxd_s == PRE_NIB) begin
              fstate <= F_PRE;
            end
          end
          F_PRE: begin
            if (!rx_dv_s || (rxd_s != PRE_NIB && rxd_s != SFD_NIB)) begin
              fstate <= F_IDLE;
            end else if (rxd_s == SFD_NIB) begin
              fstate      <= F_DA;
              nibs        <= 12'h000;
              crc         <= CRC_INIT;
              err         <= 1'b0;
              frame_start <= 1'b1;
            end
          end
          F_DA, F_SA, F_BODY: begin
            if (!rx_dv_s) begin
              fstate    <= F_IDLE;
              frame_end <= 1'b1;
              // Learning only follows a clean frame of legal length.
              if (fstate == F_BODY && !err && nibs >= MIN_FRAME_NIBS && nibs <= MAX_FRAME_NIBS
                  && !nibs[0] && (crc == CRC_RESIDUE || pcx[PCX_CRC_OFF_BIT])) begin
                sa_req <= 1'b1;
              end
            end else begin
              nibs <= nibs + 12'd1;
              crc  <= next_crc;
              err  <= err | rx_er_s;
              if (fstate == F_DA) begin
                da <= next_da;
              end
              if (fstate == F_SA) begin
                sa <= {rxd_s, sa[47:4]};
              end
              if (fstate == F_DA && nibs == DA_LAST_NIB) begin
                fstate <= F_SA;
                group  <= next_da[0];
                ftype  <= (&next_da) ? TYPE_BCAST : (next_da[0] ? TYPE_MCAST : TYPE_UCAST);
                if (!next_da[0] || pcx[PCX_GROUP_SEARCH_BIT]) begin
                  da_req <= 1'b1;
                end else begin
                  skip_done <= 1'b1;
                end
              end
              if (fstate == F_SA && nibs == SA_LAST_NIB) begin
                fstate <= F_BODY;
                // A previous source address still waiting for the CAM is not overwritten.
                if (!sa_req) begin
                  sa_hold  <= {rxd_s, sa[47:4]};
                  sa_assoc <= {2'b00, stamp, src_port};
                end
              end
            end
          end
          default: fstate <= F_IDLE;
        endcase
      end
    end
  end

  // Fields of the CAM cycle that the sequencer is about to run.
  always_comb begin
    p_cm_n = 1'b1;
    p_w_n  = 1'b0;
    p_ec_n = 1'b1;
    p_data = 16'h0000;
    p_last = 1'b0;
    case (job)
      JOB_DA: begin
        if (step < 3'd3) begin
          p_data = addr_word(da, step);
          p_ec_n = (step != 3'd2);
        end else begin
          p_w_n  = 1'b1;
          p_ec_n = 1'b0;
          p_last = 1'b1;
        end
      end
      JOB_SA: begin
        if (step < 3'd3) begin
          p_data = addr_word(sa_hold, step);
          p_ec_n = (step != 3'd2);
        end else if (step == 3'd3 && !hit) begin
          p_cm_n = 1'b0;
          p_data = LEARN_OPCODE;
        end else begin
          p_data = sa_assoc;
          p_last = 1'b1;
        end
      end
      default: begin
        p_cm_n = host_word[HOST_CM_N_BIT];
        p_w_n  = host_word[HOST_W_N_BIT];
        p_ec_n = host_word[HOST_EC_N_BIT];
        p_data = host_word[15:0];
        p_last = 1'b1;
      end
    endcase
  end

  // CAM sequencer: arbitration, then setup, strobe and recovery for each cycle.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      qstate         <= Q_IDLE;
      job            <= JOB_HOST;
      step           <= 3'd0;
      cnt            <= 4'd0;
      hit            <= 1'b0;
      rd_word        <= 16'h0000;
      da_take        <= 1'b0;
      sa_take        <= 1'b0;
      host_done      <= 1'b0;
      da_done        <= 1'b0;
      CAM_ENABLE_N   <= 1'b1;
      CAM_WRITE_N    <= 1'b1;
      CAM_COMMAND_N  <= 1'b1;
      CHAIN_ENABLE_N <= 1'b1;
      CAM_DQ_OUT     <= 16'h0000;
      CAM_DQ_OE_N    <= 1'b1;
    end else begin
      da_take   <= 1'b0;
      sa_take   <= 1'b0;
      host_done <= 1'b0;
      da_done   <= 1'b0;
      case (qstate)
        Q_IDLE: begin
          step <= 3'd0;
          hit  <= 1'b0;
          if (CAM_RESET_N) begin
            // Receive traffic always goes ahead of host accesses.
            if (da_req && !da_take) begin
              job     <= JOB_DA;
              da_take <= 1'b1;
              qstate  <= Q_SETUP;
            end else if (sa_req && !sa_take) begin
              job     <= JOB_SA;
              sa_take <= 1'b1;
              qstate  <= Q_SETUP;
            end else if (host_pending && !host_done) begin
              job    <= JOB_HOST;
              qstate <= Q_SETUP;
            end
          end
        end
        Q_SETUP: begin
          CAM_COMMAND_N  <= p_cm_n;
          CAM_WRITE_N    <= p_w_n;
          CHAIN_ENABLE_N <= p_ec_n;
          CAM_DQ_OUT     <= p_data;
          CAM_DQ_OE_N    <= p_w_n;
          qstate         <= Q_ARM;
        end
        Q_ARM: begin
          // Chain enable already stands a cycle before the strobe falls.
          CAM_ENABLE_N <= 1'b0;
          cnt          <= 4'd0;
          qstate       <= Q_STROBE;
        end
        Q_STROBE: begin
          cnt <= cnt + 4'd1;
          if (cnt == 4'(CAM_STROBE_CYC - 1)) begin
            CAM_ENABLE_N <= 1'b1;
            if (CAM_WRITE_N) begin
              rd_word <= dq_s;
            end
            if (job != JOB_HOST && step == 3'd2) begin
              hit <= ~match_n_s;
            end
            qstate <= Q_GAP;
          end
        end
        Q_GAP: begin
          CHAIN_ENABLE_N <= 1'b1;
          CAM_DQ_OE_N    <= 1'b1;
          qstate         <= Q_SETUP;
          step           <= step + 3'd1;
          if (job == JOB_DA && (p_last || (step == 3'd2 && !hit))) begin
            da_done <= 1'b1;
            qstate  <= Q_IDLE;
          end
          // A full chain cannot take a new entry, so an unknown address is dropped.
          if (job == JOB_SA && (p_last || (step == 3'd2 && !hit && !full_n_s))) begin
            qstate <= Q_IDLE;
          end
          if (job == JOB_HOST) begin
            host_done <= 1'b1;
            qstate    <= Q_IDLE;
          end
        end
        default: qstate <= Q_IDLE;
      endcase
    end
  end

  // Outcome of destination processing, searched or not.
  assign res_trig  = da_done | skip_done;
  assign res_hit   = da_done & hit;
  assign res_port  = res_hit ? rd_word[5:0] : 6'h00;
  assign same_port = res_hit & (res_port == src_port);
  always_comb begin
    res_word                                 = 16'h0000;
    res_word[RES_SRC_LSB +: 6]               = src_port;
    res_word[RES_TYPE_LSB +: 2]              = ftype;
    if (ftype == TYPE_UCAST) begin
      res_word[RES_MATCH_BIT]     = res_hit;
      res_word[RES_DST_LSB +: 6]  = res_port;
      res_word[RES_SAME_BIT]      = same_port;
    end
  end

  // Reject and the forced receive error stand until the frame ends or the next begins.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      FRAME_REJECT       <= 1'b0;
      FORWARDED_RX_ERROR <= 1'b0;
    end else begin
      FORWARDED_RX_ERROR <= rx_er_s | FRAME_REJECT;
      if (frame_end || frame_start) begin
        FRAME_REJECT <= 1'b0;
      end
      if (res_trig && (same_port || (!res_hit && group && pcx[PCX_GROUP_PROC_BIT]
                                     && pcx[PCX_DEFAULT_REJ_BIT]))) begin
        FRAME_REJECT <= 1'b1;
      end
    end
  end

  // Serial tag: destination port, high bit first, changing after receive clock rises.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tag_shift <= 6'h00;
      tag_cnt   <= 3'd0;
      TAG_VALID <= 1'b0;
      TAG_DATA  <= 1'b0;
    end else begin
      if (res_trig && res_hit && !same_port) begin
        tag_shift <= res_port;
        tag_cnt   <= 3'd6;
      end else if (rx_rise) begin
        TAG_VALID <= (tag_cnt != 3'd0);
        TAG_DATA  <= (tag_cnt != 3'd0) ? tag_shift[5] : 1'b0;
        if (tag_cnt != 3'd0) begin
          tag_shift <= {tag_shift[4:0], 1'b0};
          tag_cnt   <= tag_cnt - 3'd1;
        end
      end
    end
  end

  // Result queue; when it is full a new result is lost rather than stalling the parser.
  assign pop  = (count != '0) & (adv_pulse | apb_pop);
  assign push = res_trig & ((count != CW'(RESULT_DEPTH)) | pop);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end else begin
      if (push) begin
        res_mem[wp] <= res_word;
        wp          <= (wp == PW'(RESULT_DEPTH - 1)) ? '0 : wp + PW'(1);
      end
      if (pop) begin
        rp <= (rp == PW'(RESULT_DEPTH - 1)) ? '0 : rp + PW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  // Result port outputs, registered together so valid and data agree.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RESULT_VALID <= 1'b0;
      RESULT_DATA  <= 16'h0000;
      RESULT_OE_N  <= 1'b1;
    end else begin
      RESULT_VALID <= (count != '0);
      RESULT_DATA  <= (count != '0) ? res_mem[rp] : 16'h0000;
      RESULT_OE_N  <= ~sel_s;
    end
  end

endmodule : mac_address_filter_engine

/* File: design/mac_filter_pkg.sv */
package mac_filter_pkg;

  // System clock rate, used to turn times into cycle counts.
  localparam int CLK_MHZ = 25;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_SYS_DYNAMIC_CONFIG   = 8'h00;
  localparam logic [7:0] OFF_PORT_CONFIG_EXTENDED = 8'h04;
  localparam logic [7:0] OFF_SOURCE_PORT          = 8'h08;
  localparam logic [7:0] OFF_TIME_STAMP           = 8'h0c;
  localparam logic [7:0] OFF_RESULT_DATA          = 8'h10;
  localparam logic [7:0] OFF_STATUS               = 8'h14;
  localparam logic [7:0] OFF_HOST_CAM             = 8'h18;

  // Field positions.
  localparam int CFG_CAM_RUN_BIT      = 0;
  localparam int PCX_GROUP_SEARCH_BIT = 0;
  localparam int PCX_GROUP_PROC_BIT   = 1;
  localparam int PCX_DEFAULT_REJ_BIT  = 2;
  localparam int PCX_CRC_OFF_BIT      = 3;
  localparam int HOST_CM_N_BIT        = 16;
  localparam int HOST_W_N_BIT         = 17;
  localparam int HOST_EC_N_BIT        = 18;
  localparam int HOST_BUSY_BIT        = 31;
  localparam int RES_SRC_LSB          = 10;
  localparam int RES_TYPE_LSB         = 8;
  localparam int RES_MATCH_BIT        = 7;
  localparam int RES_DST_LSB          = 1;
  localparam int RES_SAME_BIT         = 0;
  localparam int ASSOC_STAMP_LSB      = 6;
  localparam int RES_VALID_BIT        = 16;

  // Reset values.
  localparam logic [3:0]  PCX_RESET   = 4'h0;
  localparam logic [5:0]  PORT_RESET  = 6'h00;
  localparam logic [7:0]  STAMP_RESET = 8'h00;

  // Frame type codes.
  localparam logic [1:0] TYPE_BCAST = 2'b00;
  localparam logic [1:0] TYPE_MCAST = 2'b01;
  localparam logic [1:0] TYPE_UCAST = 2'b10;

  // Receive framing: nibble values and lengths counted from the first address nibble.
  localparam logic [3:0]  PRE_NIB        = 4'h5;
  localparam logic [3:0]  SFD_NIB        = 4'hd;
  localparam logic [11:0] DA_LAST_NIB    = 12'd11;
  localparam logic [11:0] SA_LAST_NIB    = 12'd23;
  localparam logic [11:0] MIN_FRAME_NIBS = 12'd128;
  localparam logic [11:0] MAX_FRAME_NIBS = 12'd3036;

  // Frame check sequence, reflected form.
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

  // CAM strobe: least low time plus the two synchroniser stages on the flags.
  localparam int CAM_STROBE_NS  = 80;
  localparam int SYNC_STAGES    = 2;
  localparam int CAM_STROBE_CYC = (CAM_STROBE_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;

  typedef enum {F_IDLE, F_PRE, F_DA, F_SA, F_BODY} frame_state_t;
  typedef enum {Q_IDLE, Q_SETUP, Q_ARM, Q_STROBE, Q_GAP} seq_state_t;
  typedef enum {JOB_DA, JOB_SA, JOB_HOST} job_t;

endpackage : mac_filter_pkg

/* File: sim/mac_filter_monitor.sv */
`timescale 1ns/1ps
module mac_filter_monitor (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        FRAME_REJECT,
  input wire logic        FORWARDED_RX_ERROR,
  input wire logic        TAG_VALID,
  input wire logic [15:0] RESULT_DATA,
  input wire logic        RESULT_VALID,
  input wire logic        RESULT_OE_N,
  input wire logic        RESULT_SELECT,
  input wire logic        CAM_ENABLE_N,
  input wire logic        CAM_WRITE_N,
  input wire logic        CAM_DQ_OE_N,
  input wire logic        CHAIN_ENABLE_N,
  input wire logic        CAM_RESET_N
);
  // All checks share the system clock and its reset.
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  ready_now_a: assert property (PSEL |-> PREADY) else $error("bus not ready");
  unmapped_err_a: assert property (PSEL && PENABLE && PADDR == 8'h40 |-> PSLVERR)
    else $error("no slave error");
  cam_idle_a: assert property (!CAM_RESET_N |-> CAM_ENABLE_N) else $error("cam strobe");
  strobe_len_a: assert property ($fell(CAM_ENABLE_N) |-> !CAM_ENABLE_N[*4] ##1 CAM_ENABLE_N)
    else $error("strobe length");
  chain_hold_a: assert property ($fell(CAM_ENABLE_N) |-> $stable(CHAIN_ENABLE_N)[*4])
    else $error("chain enable moved");
  write_drive_a: assert property (!CAM_ENABLE_N && !CAM_WRITE_N |-> !CAM_DQ_OE_N)
    else $error("bus not driven");
  reject_err_a: assert property (FRAME_REJECT |=> FORWARDED_RX_ERROR) else $error("no error");
  empty_zero_a: assert property (!RESULT_VALID |-> RESULT_DATA == 16'h0000)
    else $error("stale result");
  tag_reject_a: assert property (TAG_VALID |-> !FRAME_REJECT) else $error("tag on reject");
  // Without select or bus reads nothing may pop the head result.
  sel_hold_a: assert property ((!RESULT_SELECT && !PSEL)[*6] ##0 RESULT_VALID |=>
    RESULT_VALID && $stable(RESULT_DATA)) else $error("result moved");
  oe_sel_a: assert property (!RESULT_SELECT[*5] |-> RESULT_OE_N) else $error("port driven");
endmodule : mac_filter_monitor
bind mac_address_filter_engine mac_filter_monitor mon_u (.*);

/* File: sim/cam_chain_model.sv */
`timescale 1ns/1ps
module cam_chain_model (
  input wire logic        e_n,
  input wire logic        w_n,
  input wire logic        ec_n,
  input wire logic        hit,
  input wire logic        full,
  input wire logic [5:0]  port,
  output logic     [15:0] dq,
  output logic            match_n,
  output logic            full_n
);
  // The last device of the chain presents the flags; the chain is one device here.
  assign full_n = !full;
  initial match_n = 1'b1;
  initial dq = 16'h5a5a;
  // The flag is enabled only when the chain enable is low at the strobe edge.
  always @(negedge e_n) begin
    match_n <= !(hit && !ec_n);
    if (w_n) dq <= {10'h000, port};
  end
  // Released bus shows no stale word, so a late sample cannot pass.
  always @(posedge e_n) dq <= ~dq;
endmodule : cam_chain_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb import mac_filter_pkg::*;;
  logic CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, RX_CLK = 0, RX_DV = 0;
  logic RX_ER = 0, RESULT_SELECT = 0, RESULT_ADVANCE = 0, hit = 0;
  logic [5:0] tag_bits = 0;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic [3:0] RXD = 0;
  logic [15:0] RESULT_DATA, CAM_DQ_IN, CAM_DQ_OUT;
  logic PREADY, PSLVERR, FRAME_REJECT, FORWARDED_RX_ERROR, TAG_VALID, TAG_DATA, RESULT_OE_N;
  logic RESULT_VALID, CAM_DQ_OE_N, CAM_ENABLE_N, CAM_WRITE_N, CAM_COMMAND_N, CHAIN_ENABLE_N;
  logic MATCH_IN_N, FULL_IN_N, CAM_RESET_N, err;
  int fail_count = 0, check_count = 0;
  always #20 CLK = ~CLK;
  // Tag bits are taken mid-bit, at the falling edge of the link clock.
  always @(negedge RX_CLK) if (TAG_VALID === 1'b1) tag_bits <= {tag_bits[4:0], TAG_DATA};
  mac_address_filter_engine dut_u (.*);
  cam_chain_model cam_u (.e_n(CAM_ENABLE_N), .w_n(CAM_WRITE_N), .ec_n(CHAIN_ENABLE_N),
    .hit(hit), .full(1'b0), .port(6'd5), .dq(CAM_DQ_IN), .match_n(MATCH_IN_N), .full_n(FULL_IN_N));
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One transfer; the request stands until pready is seen high.
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge CLK); PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK); PENABLE <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    if (i == 50) begin fail_count++; end_sim(); end
    rd = PRDATA; err = PSLVERR;
    PSEL <= 0; PENABLE <= 0;
  endtask : apb
  // The link clock runs through the frame and one idle nibble, so the end is seen.
  task frame(logic [3:0] da0, logic [3:0] dan);
    for (int i = 0; i < 42; i++) begin
      @(posedge CLK); RX_DV <= i < 41; RX_CLK <= 1;
      RXD <= i < 15 ? PRE_NIB : i == 15 ? SFD_NIB : i == 16 ? da0 : i < 28 ? dan : 4'h3;
      repeat (4) @(posedge CLK); RX_CLK <= 0; repeat (3) @(posedge CLK);
    end
    @(posedge CLK); RX_DV <= 0; RXD <= 4'ha;
  endtask : frame
  task wait_res;
    int i;
    for (i = 0; i < 600 && RESULT_VALID !== 1'b1; i++) @(posedge CLK);
    if (i == 600) begin fail_count++; end_sim(); end
    repeat (3) @(posedge CLK);
  endtask : wait_res
  task t_same;
    hit = 1;
    fork frame(4'h2, 4'h2); begin wait_res(); chk("reject", 1, FRAME_REJECT);
      chk("fwd error", 1, FORWARDED_RX_ERROR); end join
    chk("result", {6'd5, 2'b10, 1'b1, 6'd5, 1'b1}, RESULT_DATA);
    apb(0, OFF_RESULT_DATA, 0);
    chk("host result", {15'd0, 1'b1, 6'd5, 2'b10, 1'b1, 6'd5, 1'b1}, rd);
  endtask : t_same
  task t_group;
    hit = 0;
    apb(1, OFF_PORT_CONFIG_EXTENDED, 32'h7);
    fork frame(4'h1, 4'h0); begin wait_res(); chk("group reject", 1, FRAME_REJECT); end join
    chk("mcast", {6'd5, TYPE_MCAST, 8'h00}, RESULT_DATA);
    apb(0, OFF_RESULT_DATA, 0);
  endtask : t_group
  task t_adv;
    apb(1, OFF_PORT_CONFIG_EXTENDED, 0);
    apb(1, OFF_SOURCE_PORT, 6);
    frame(4'hf, 4'hf);
    hit = 1;
    frame(4'h2, 4'h2);
    chk("tag", 6'd5, tag_bits);
    chk("head", {6'd6, TYPE_BCAST, 8'h00}, RESULT_DATA);
    @(posedge CLK); RESULT_ADVANCE <= 1; repeat (8) @(posedge CLK); RESULT_ADVANCE <= 0;
    repeat (8) @(posedge CLK); chk("ignored advance", 16'h1800, RESULT_DATA);
    RESULT_SELECT <= 1;
    for (int k = 0; k < 2; k++) begin
      repeat (8) @(posedge CLK); RESULT_ADVANCE <= 1; repeat (8) @(posedge CLK);
      RESULT_ADVANCE <= 0;
      if (k == 0) chk("next", {6'd6, TYPE_UCAST, 1'b1, 6'd5, 1'b0}, RESULT_DATA);
    end
    repeat (8) @(posedge CLK); chk("empty", 0, {RESULT_VALID, RESULT_DATA});
    chk("port drive", 0, RESULT_OE_N);
  endtask : t_adv
  initial begin
    repeat (4) @(posedge CLK);
    RESETN <= 1;
    @(posedge CLK); chk("cam reset", 0, CAM_RESET_N);
    apb(0, 8'h40, 0); chk("slave error", 1, err);
    chk("unmapped data", 0, rd);
    apb(1, OFF_SYS_DYNAMIC_CONFIG, 1);
    apb(1, OFF_SOURCE_PORT, 5);
    chk("cam run", 1, CAM_RESET_N);
    t_same();
    t_group();
    t_adv();
    end_sim();
  end
endmodule : tb
